// >>> dv/tsg_testbench.sv
`timescale 1ns/1ns
module testbench
   import tsg_pkg::*;
;
   logic clk, rst_n;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, rnd;
   logic [3:0] s_axi_wstrb, ch_event, ch_is_input, ch_capture_read;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp, centre_mode;
   logic commutation_event, trigger_event, break_active, update_event_in, count_down;
   logic [15:0] auto_reload_value, counter_load_value, upd_val, st, en;
   logic update_event, prescaler_count_clear, counter_load, irq;
   logic [6:0] sw_event_gen, sw_seen;
   int n_errors, n_checks, n_upd, sw_cyc, i, k;

   tsg_timer_status dut_u (.clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ch_event,
      .ch_is_input, .ch_capture_read, .commutation_event, .trigger_event, .break_active,
      .update_event_in, .count_down, .centre_mode, .auto_reload_value, .update_event,
      .prescaler_count_clear, .counter_load, .counter_load_value, .sw_event_gen, .irq);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic f_irq(input logic [15:0] s, input logic [15:0] e);
      return |(s[7:0] & e[7:0]);
   endfunction : f_irq

   function automatic logic [15:0] f_load(input logic cd, input logic [1:0] cm,
                                          input logic [15:0] arr);
      return (cd && cm == TSG_EDGE_ALIGNED) ? arr : 16'h0000;
   endfunction : f_load

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic tmo(input int n);
      if (n >= 40) begin
         n_errors++;
         $display("[ERR] handshake expected answer seen none");
         wrap_up();
      end
   endtask : tmo

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      int n;
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 40 && !(ad && wd); n++) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      tmo(n);
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_bvalid === 1'b1) break;
      end
      tmo(n);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_arready === 1'b1) break;
      end
      tmo(n);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_rvalid === 1'b1) break;
      end
      tmo(n);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rdr

   // status read back plus interrupt level against the model
   task automatic cst(input string nm);
      rdr(TSG_STATUS_OFFSET);
      chk(nm, {16'h0000, st}, rd);
      chk("irq", {31'h0, f_irq(st, en)}, {31'h0, irq});
   endtask : cst

   always @(posedge clk) begin
      if (update_event === 1'b1) begin
         n_upd <= n_upd + 1;
         upd_val <= counter_load_value;
         chk("update_side", 32'h3, {30'h0, counter_load, prescaler_count_clear});
      end
   end

   // software event pulses: which lines fired and for how many cycles
   always @(posedge clk) begin
      if ((|sw_event_gen) === 1'b1) begin
         sw_seen <= sw_seen | sw_event_gen;
         sw_cyc <= sw_cyc + 1;
      end
   end

   initial begin
      {rst_n, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {ch_event, ch_is_input, ch_capture_read, commutation_event, trigger_event} = '0;
      {break_active, update_event_in, count_down, centre_mode, auto_reload_value} = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      {n_errors, n_checks, n_upd, st, en, upd_val} = '0;
      void'($urandom(32'h069c774a));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdr(TSG_ENABLE_OFFSET);
      chk("enable_reset", {16'h0000, TSG_ENABLE_RESET}, rd);
      cst("status_reset");
      rdr(TSG_EVGEN_OFFSET);
      chk("evgen_read", 32'h0, rd);
      rdr(8'h04);
      chk("unmapped_read", {30'h0, TSG_RESP_SLVERR}, {30'h0, rsp});
      wr(8'h20, 16'hffff);
      chk("unmapped_write", {30'h0, TSG_RESP_SLVERR}, {30'h0, rsp});
      wr(TSG_ENABLE_OFFSET, 16'hffff);
      en = TSG_ENABLE_IMPL;
      rdr(TSG_ENABLE_OFFSET);
      chk("enable_rw", {16'h0000, TSG_ENABLE_IMPL}, rd);
      $display("test registers done");
      for (i = 0; i < 24; i++) begin
         rnd = $urandom;
         ch_event <= rnd[3:0];
         ch_is_input <= rnd[7:4];
         ch_capture_read <= rnd[11:8];
         commutation_event <= rnd[12];
         trigger_event <= rnd[13];
         @(posedge clk);
         {ch_event, ch_capture_read, commutation_event, trigger_event} <= '0;
         for (k = 0; k < 4; k++) begin
            if (rnd[k]) begin
               if (rnd[4+k] && st[1+k]) st[9+k] = 1'b1;
               st[1+k] = 1'b1;
            end else if (rnd[8+k]) st[1+k] = 1'b0;
         end
         st[5] = st[5] | rnd[12];
         st[6] = st[6] | rnd[13];
         cst("status_events");
         wr(TSG_STATUS_OFFSET, rnd[31:16]);
         st = st & rnd[31:16];
         en = 16'(rnd[23:14]);
         wr(TSG_ENABLE_OFFSET, en);
         cst("status_clear");
      end
      $display("test events done");
      wr(TSG_STATUS_OFFSET, 16'h0000);
      st = 16'h0000;
      en = 16'h0080;
      wr(TSG_ENABLE_OFFSET, en);
      break_active <= 1'b1;
      repeat (2) @(posedge clk);
      wr(TSG_STATUS_OFFSET, 16'h0000);
      st = 16'h0080;
      cst("break_held");
      break_active <= 1'b0;
      @(posedge clk);
      wr(TSG_STATUS_OFFSET, 16'h0000);
      st = 16'h0000;
      cst("break_cleared");
      $display("test break done");
      for (i = 0; i < 8; i++) begin
         rnd = $urandom;
         count_down <= i[0];
         centre_mode <= i[2:1];
         auto_reload_value <= rnd[15:0];
         @(posedge clk);
         k = n_upd;
         wr(TSG_EVGEN_OFFSET, 16'h0001);
         repeat (3) @(posedge clk);
         chk("update_count", k + 1, n_upd);
         chk("load_value", {16'h0, f_load(i[0], i[2:1], rnd[15:0])}, {16'h0, upd_val});
      end
      st[0] = 1'b1;
      cst("update_flag");
      k = n_upd;
      wr(TSG_EVGEN_OFFSET, 16'h0000);
      repeat (3) @(posedge clk);
      chk("update_none", k, n_upd);
      update_event_in <= 1'b1;
      @(posedge clk);
      update_event_in <= 1'b0;
      repeat (2) @(posedge clk);
      chk("update_hw", k + 1, n_upd);
      $display("test update done");
      for (i = 0; i < 8; i++) begin
         rnd = $urandom;
         sw_seen = 7'h00;
         sw_cyc = 0;
         k = n_upd;
         ch_is_input <= rnd[3:0];
         @(posedge clk);
         wr(TSG_EVGEN_OFFSET, {8'h00, rnd[11:5], 1'b0});
         repeat (2) @(posedge clk);
         chk("sw_event_gen", {25'h0, rnd[11:5]}, {25'h0, sw_seen});
         chk("sw_event_cycles", {31'h0, |rnd[11:5]}, sw_cyc);
         chk("sw_no_update", k, n_upd);
         for (k = 0; k < 4; k++) begin
            if (rnd[5+k]) begin
               if (rnd[k] && st[1+k]) st[9+k] = 1'b1;
               st[1+k] = 1'b1;
            end
         end
         st[7:5] = st[7:5] | rnd[11:9];
         cst("sw_events");
         s_axi_wstrb <= 4'h2;
         wr(TSG_STATUS_OFFSET, 16'h0000);
         s_axi_wstrb <= 4'hf;
         st[15:8] = 8'h00;
         cst("strobe_clear");
         wr(TSG_STATUS_OFFSET, rnd[31:16]);
         st = st & rnd[31:16];
      end
      cst("sw_cleared");
      $display("test swgen done");
      wrap_up();
   end
endmodule : testbench

// >>> hw/tsg_pkg.sv
package tsg_pkg;
   // register bus geometry
   localparam int TSG_ADDR_W = 8;
   localparam int TSG_DATA_W = 32;
   localparam int TSG_REG_W = 16;
   localparam int TSG_CHANNELS = 4;

   // register byte offsets
   localparam logic [7:0] TSG_ENABLE_OFFSET = 8'h0c;
   localparam logic [7:0] TSG_STATUS_OFFSET = 8'h10;
   localparam logic [7:0] TSG_EVGEN_OFFSET = 8'h14;

   // reset values
   localparam logic [15:0] TSG_STATUS_RESET = 16'h0000;
   localparam logic [15:0] TSG_ENABLE_RESET = 16'h0000;
   localparam logic [7:0] TSG_EVGEN_RESET = 8'h00;

   // status field positions
   localparam int TSG_UPDATE_BIT = 0;
   localparam int TSG_CH1_FLAG_BIT = 1;
   localparam int TSG_COMMUTATION_BIT = 5;
   localparam int TSG_TRIGGER_BIT = 6;
   localparam int TSG_BREAK_BIT = 7;
   localparam int TSG_CH1_OVERCAPTURE_BIT = 9;

   // implemented status bits; 8 and 15:13 stay zero
   localparam logic [15:0] TSG_STATUS_IMPL = 16'h1eff;
   // enable register: bit 15 unused
   localparam logic [15:0] TSG_ENABLE_IMPL = 16'h7fff;

   // event generation field positions
   localparam int TSG_UPDATE_REQUEST_BIT = 0;
   localparam int TSG_CH1_GEN_BIT = 1;
   localparam int TSG_COMMUTATION_GEN_BIT = 5;
   localparam int TSG_TRIGGER_GEN_BIT = 6;
   localparam int TSG_BREAK_GEN_BIT = 7;

   // counter alignment mode encodings
   localparam logic [1:0] TSG_EDGE_ALIGNED = 2'h0;

   // bus responses
   localparam logic [1:0] TSG_RESP_OKAY = 2'h0;
   localparam logic [1:0] TSG_RESP_SLVERR = 2'h2;
endpackage : tsg_pkg

// >>> hw/tsg_timer_status.sv
`timescale 1ns/1ns
module tsg_timer_status
   import tsg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // axi4-lite write address
   input wire logic [TSG_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [TSG_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [TSG_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [TSG_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // channel events from the capture/compare channels
   input wire logic [TSG_CHANNELS-1:0] ch_event,
   input wire logic [TSG_CHANNELS-1:0] ch_is_input,
   input wire logic [TSG_CHANNELS-1:0] ch_capture_read,
   // other timer events
   input wire logic commutation_event,
   input wire logic trigger_event,
   input wire logic break_active,
   input wire logic update_event_in,
   // counter configuration
   input wire logic count_down,
   input wire logic [1:0] centre_mode,
   input wire logic [TSG_REG_W-1:0] auto_reload_value,
   // update effects on counter core and prescaler
   output logic update_event,
   output logic prescaler_count_clear,
   output logic counter_load,
   output logic [TSG_REG_W-1:0] counter_load_value,
   // software generated events towards the channels and break logic
   output logic [6:0] sw_event_gen,
   // interrupt
   output logic irq
);

   logic aw_held_reg;
   logic [TSG_ADDR_W-1:0] aw_addr_reg;
   logic w_held_reg;
   logic [TSG_DATA_W-1:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [TSG_DATA_W-1:0] rdata_reg;
   logic [TSG_REG_W-1:0] status_reg;
   logic [TSG_REG_W-1:0] status_next;
   logic [TSG_REG_W-1:0] enable_reg;
   logic [7:0] evgen_reg;
   logic update_event_reg;
   logic [TSG_REG_W-1:0] counter_load_value_reg;
   logic wr_fire;
   logic wr_status;
   logic wr_enable;
   logic wr_evgen;
   logic wr_mapped;
   logic [TSG_REG_W-1:0] be_mask;
   logic [TSG_REG_W-1:0] flag_set;
   logic [TSG_REG_W-1:0] flag_clear;
   logic [TSG_CHANNELS-1:0] ch_hit;
   logic update_fire;
   logic [TSG_REG_W-1:0] rd_value;
   logic rd_mapped;

   // ---------------- write channel ----------------
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_status = wr_fire && (aw_addr_reg == TSG_STATUS_OFFSET);
   assign wr_enable = wr_fire && (aw_addr_reg == TSG_ENABLE_OFFSET);
   assign wr_evgen = wr_fire && (aw_addr_reg == TSG_EVGEN_OFFSET) && w_strb_reg[0];
   assign wr_mapped = (aw_addr_reg == TSG_STATUS_OFFSET) ||
                      (aw_addr_reg == TSG_ENABLE_OFFSET) ||
                      (aw_addr_reg == TSG_EVGEN_OFFSET);
   assign be_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         w_held_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= TSG_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_mapped ? TSG_RESP_OKAY : TSG_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   // ---------------- read channel ----------------
   assign s_axi_arready = !rvalid_reg;

   always_comb begin
      rd_mapped = 1'b1;
      unique case (s_axi_araddr)
         TSG_ENABLE_OFFSET: rd_value = enable_reg;
         TSG_STATUS_OFFSET: rd_value = status_reg & TSG_STATUS_IMPL;
         TSG_EVGEN_OFFSET: rd_value = '0;
         default: begin
            rd_value = '0;
            rd_mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= TSG_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= {{(TSG_DATA_W-TSG_REG_W){1'b0}}, rd_value};
         rresp_reg <= rd_mapped ? TSG_RESP_OKAY : TSG_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   // ---------------- enable register ----------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_reg <= TSG_ENABLE_RESET;
      end else if (wr_enable) begin
         enable_reg <= ((enable_reg & ~be_mask) | (w_data_reg[15:0] & be_mask))
                       & TSG_ENABLE_IMPL;
      end
   end

   // ---------------- event generation ----------------
   // each written one lives for exactly one cycle, then hardware clears it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         evgen_reg <= TSG_EVGEN_RESET;
      end else if (wr_evgen) begin
         evgen_reg <= w_data_reg[7:0];
      end else begin
         evgen_reg <= TSG_EVGEN_RESET;
      end
   end

   assign sw_event_gen = evgen_reg[TSG_BREAK_GEN_BIT:TSG_CH1_GEN_BIT];
   assign update_fire = evgen_reg[TSG_UPDATE_REQUEST_BIT] || update_event_in;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         update_event_reg <= 1'b0;
         counter_load_value_reg <= '0;
      end else begin
         update_event_reg <= update_fire;
         if (update_fire) begin
            if (count_down && (centre_mode == TSG_EDGE_ALIGNED)) begin
               counter_load_value_reg <= auto_reload_value;
            end else begin
               counter_load_value_reg <= '0;
            end
         end
      end
   end

   assign update_event = update_event_reg;
   // only the running count is cleared; the division factor lives elsewhere
   assign prescaler_count_clear = update_event_reg;
   assign counter_load = update_event_reg;
   assign counter_load_value = counter_load_value_reg;

   // ---------------- status flags ----------------
   for (genvar i = 0; i < TSG_CHANNELS; i++) begin : g_ch
      assign ch_hit[i] = ch_event[i] || evgen_reg[TSG_CH1_GEN_BIT+i];
   end

   always_comb begin
      flag_set = '0;
      flag_set[TSG_UPDATE_BIT] = update_fire;
      for (int i = 0; i < TSG_CHANNELS; i++) begin
         flag_set[TSG_CH1_FLAG_BIT+i] = ch_hit[i];
         flag_set[TSG_CH1_OVERCAPTURE_BIT+i] = ch_hit[i] && ch_is_input[i] &&
            status_reg[TSG_CH1_FLAG_BIT+i];
      end
      flag_set[TSG_COMMUTATION_BIT] = commutation_event ||
         evgen_reg[TSG_COMMUTATION_GEN_BIT];
      flag_set[TSG_TRIGGER_BIT] = trigger_event || evgen_reg[TSG_TRIGGER_GEN_BIT];
      flag_set[TSG_BREAK_BIT] = break_active || evgen_reg[TSG_BREAK_GEN_BIT];
   end

   always_comb begin
      flag_clear = '0;
      if (wr_status) begin
         flag_clear = be_mask & ~w_data_reg[15:0];
      end
      for (int i = 0; i < TSG_CHANNELS; i++) begin
         if (ch_capture_read[i]) begin
            flag_clear[TSG_CH1_FLAG_BIT+i] = 1'b1;
         end
      end
   end
   // set wins over clear, so a held break input defeats a clear
   assign status_next = ((status_reg & ~flag_clear) | flag_set) & TSG_STATUS_IMPL;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= TSG_STATUS_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   assign irq = |(status_reg[TSG_BREAK_BIT:0] & enable_reg[TSG_BREAK_BIT:0]);

   // ---------------- assertions ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_ch_flags;
      (ch_event[1] |=> status_reg[2]) and (ch_event[3] |=> status_reg[4]);
   endproperty
   a_ch_flags: assert property (p_ch_flags) else $error("channel flag not set");
   property p_commutation;
      commutation_event |=> status_reg[5] ##1 (status_reg[5] || $past(wr_status));
   endproperty
   a_commutation: assert property (p_commutation) else $error("commutation flag");
   property p_trigger_hold;
      status_reg[6] && !wr_status |=> status_reg[6];
   endproperty
   a_trigger_hold: assert property (p_trigger_hold) else $error("trigger flag lost");
   property p_break;
      break_active [*2] |-> status_reg[7];
   endproperty
   a_break: assert property (p_break) else $error("break flag clear while active");
   property p_overcapture1;
      ch_event[0] && ch_is_input[0] && status_reg[1] |=> status_reg[9];
   endproperty
   a_overcapture1: assert property (p_overcapture1) else $error("ch1 overcapture");
   property p_overcapture_input;
      $rose(status_reg[12]) |-> $past(ch_is_input[3]);
   endproperty
   a_overcapture_input: assert property (p_overcapture_input)
      else $error("ch4 overcapture in output mode");
   property p_update_request;
      wr_evgen && w_data_reg[0] |=> evgen_reg[0] ##1 (update_event && !evgen_reg[0]);
   endproperty
   a_update_request: assert property (p_update_request) else $error("update request");
   property p_prescaler_clear;
      update_fire |=> prescaler_count_clear && counter_load;
   endproperty
   a_prescaler_clear: assert property (p_prescaler_clear) else $error("prescaler clear");
   property p_load_reload;
      update_fire && count_down && centre_mode == TSG_EDGE_ALIGNED
         |=> counter_load_value == $past(auto_reload_value);
   endproperty
   a_load_reload: assert property (p_load_reload) else $error("down load value");
   property p_load_zero;
      update_fire && (!count_down || centre_mode != TSG_EDGE_ALIGNED)
         |=> counter_load_value == '0;
   endproperty
   a_load_zero: assert property (p_load_zero) else $error("up load value");
   property p_read_clear;
      ch_capture_read[0] && !ch_hit[0] |=> !status_reg[1];
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("ch1 read clear");
   // an enable write in the same cycle may legally drop the mask bit
   property p_break_irq;
      break_active && enable_reg[7] && !wr_enable |=> irq;
   endproperty
   a_break_irq: assert property (p_break_irq) else $error("break irq missing");
   property p_reserved;
      status_reg[8] == 1'b0 && status_reg[15:13] == 3'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved status set");
   property p_write_one_keeps;
      status_reg[5] && wr_status && w_data_reg[5] |=> status_reg[5];
   endproperty
   a_write_one_keeps: assert property (p_write_one_keeps)
      else $error("write one cleared flag");
endmodule : tsg_timer_status
